//--- logic/lmds_regs.svh
`ifndef LMDS_REGS_SVH
`define LMDS_REGS_SVH

// Divider iterations, one quotient bit per clock
`define LMDS_DIV_STEPS 6'd32
`define LMDS_DIV_LAST 6'd31
// Fixed lane widths of the saturating lane operations
`define LMDS_WORD_N 6'd32
`define LMDS_HALF_N 6'd16
`define LMDS_BYTE_N 6'd8
// Sticky saturation flag after reset
`define LMDS_Q_RST 1'b0

`endif

//--- logic/lmds_pkg.sv
package lmds_pkg;

    typedef enum logic [4:0] {
        op_unsigned_long_multiply = 5'h00,
        op_unsigned_long_multiply_accumulate = 5'h01,
        op_signed_long_multiply = 5'h02,
        op_signed_long_multiply_accumulate = 5'h03,
        op_signed_divide = 5'h04,
        op_unsigned_divide = 5'h05,
        op_signed_saturate = 5'h06,
        op_unsigned_saturate = 5'h07,
        op_signed_saturate_halfwords = 5'h08,
        op_unsigned_saturate_halfwords = 5'h09,
        op_saturating_add = 5'h0a,
        op_saturating_subtract = 5'h0b,
        op_saturating_subtract_halfwords = 5'h0c,
        op_saturating_add_sub_exchange = 5'h0d,
        op_saturating_sub_add_exchange = 5'h0e,
        op_saturating_double_add = 5'h0f,
        op_saturating_double_subtract = 5'h10,
        op_unsigned_sat_add_halfwords = 5'h11,
        op_unsigned_sat_add_bytes = 5'h12,
        op_unsigned_sat_add_sub_exchange = 5'h13,
        op_unsigned_sat_sub_add_exchange = 5'h14,
        op_unsigned_sat_subtract_halfwords = 5'h15,
        op_unsigned_sat_subtract_bytes = 5'h16
    } lmds_op_t;

    typedef enum logic [1:0] {
        lmds_st_idle = 2'b01,
        lmds_st_div = 2'b10
    } lmds_state_t;

    typedef struct packed {
        lmds_state_t st;
        logic [5:0] cnt;
        logic [31:0] quo;
        logic [31:0] rem;
        logic [31:0] dvs;
        logic neg;
        logic dzero;
        logic [3:0] dst;
        logic busy;
        logic vld;
        logic [31:0] lo;
        logic [31:0] hi;
        logic hi_we;
        logic [3:0] lo_idx;
        logic [3:0] hi_idx;
        logic q;
    } lmds_regs_t;

endpackage

//--- logic/lmds_sat_if.sv
`timescale 1ns/1ps
interface lmds_sat_if #(
    parameter int IW = 34
);
    logic signed [IW-1:0] val;
    logic [5:0] n;
    logic uns;
    logic signed [IW-1:0] res;
    logic sat;

    modport drv(output val, output n, output uns, input res, input sat);
    modport lane(input val, input n, input uns, output res, output sat);
endinterface

//--- logic/lmds_sat_lane.sv
`timescale 1ns/1ps
module lmds_sat_lane #(
    parameter int IW = 34
) (
    lmds_sat_if.lane bus // Value in, clamped value and flag out
);
    localparam logic signed [IW-1:0] ONE = {{(IW-1){1'b0}}, 1'b1};

    logic signed [IW-1:0] hi;
    logic signed [IW-1:0] lo;

    // ========================================
    // Clamp to the n-bit range
    always_comb begin
        if (bus.uns) begin
            hi = (ONE << bus.n) - ONE;
            lo = '0;
        end else begin
            hi = (ONE << (bus.n - 6'd1)) - ONE;
            lo = -(ONE << (bus.n - 6'd1));
        end
        if (bus.val < lo) begin
            bus.res = lo;
            bus.sat = 1'b1;
        end else if (bus.val > hi) begin
            bus.res = hi;
            bus.sat = 1'b1;
        end else begin
            bus.res = bus.val;
            bus.sat = 1'b0;
        end
    end
endmodule // lmds_sat_lane

//--- logic/lmds_unit.sv
`timescale 1ns/1ps
`include "lmds_regs.svh"

module lmds_unit
    import lmds_pkg::*;
(
    input wire logic ref_clk_in, // Core clock
    input wire logic srst_in, // Sync reset, high
    input wire logic req_valid_in, // Operation request
    input wire lmds_op_t op_in, // Operation select
    input wire logic [31:0] opa_in, // First operand
    input wire logic [31:0] opb_in, // Second operand
    input wire logic [31:0] acc_lo_in, // Accumulate low word
    input wire logic [31:0] acc_hi_in, // Accumulate high word
    input wire logic [5:0] sat_n_in, // Saturation width
    input wire logic shift_right_in, // Preshift right when set
    input wire logic [4:0] shift_amt_in, // Preshift amount
    input wire logic [3:0] dest_lo_idx_in, // Low or only destination
    input wire logic [3:0] dest_hi_idx_in, // High destination
    input wire logic [3:0] first_idx_in, // Dividend register
    input wire logic dest_omitted_in, // Divide names no destination
    input wire logic status_wr_in, // Status register write
    input wire logic status_q_in, // Flag value written
    output logic busy_out, // Divide in progress
    output logic res_valid_out, // Result write pulse
    output logic [31:0] res_lo_out, // Low or only result
    output logic [31:0] res_hi_out, // High result
    output logic res_hi_we_out, // High result is written
    output logic [3:0] res_lo_idx_out, // Low result register
    output logic [3:0] res_hi_idx_out, // High result register
    output logic q_flag_out // Sticky saturation flag
);
    lmds_regs_t s_r;
    lmds_regs_t s_nxt;

    logic take;
    logic [63:0] prod_u;
    logic [63:0] prod_s;
    logic [31:0] shifted;
    logic [32:0] trial;
    logic [32:0] diff;
    logic ge;
    logic [31:0] qnew;
    logic is_half;
    logic is_byte;
    logic hsgn;
    logic hadd;
    logic [15:0] ah;
    logic [15:0] bo;

    logic signed [33:0] wv [2];
    logic [5:0] wn [2];
    logic wu [2];
    logic signed [33:0] wr [2];
    logic ws [2];
    logic signed [17:0] hv [2];
    logic [5:0] hn [2];
    logic hu [2];
    logic signed [17:0] hr [2];
    logic hs [2];
    logic signed [9:0] bv [4];
    logic bu [4];
    logic signed [9:0] br [4];

    assign take = req_valid_in & ~s_r.busy;

    // ========================================
    // Clamp lanes
    for (genvar g = 0; g < 2; g++) begin : g_word
        lmds_sat_if #(.IW(34)) w_if();
        assign w_if.val = wv[g];
        assign w_if.n = wn[g];
        assign w_if.uns = wu[g];
        assign wr[g] = w_if.res;
        assign ws[g] = w_if.sat;
        lmds_sat_lane #(.IW(34)) u_lane(.bus(w_if.lane));
    end
    for (genvar g = 0; g < 2; g++) begin : g_half
        lmds_sat_if #(.IW(18)) h_if();
        assign h_if.val = hv[g];
        assign h_if.n = hn[g];
        assign h_if.uns = hu[g];
        assign hr[g] = h_if.res;
        assign hs[g] = h_if.sat;
        lmds_sat_lane #(.IW(18)) u_lane(.bus(h_if.lane));
    end
    // Byte lanes never touch the flag, so their sat output is unused
    for (genvar g = 0; g < 4; g++) begin : g_byte
        lmds_sat_if #(.IW(10)) b_if();
        assign b_if.val = bv[g];
        assign b_if.n = `LMDS_BYTE_N;
        assign b_if.uns = bu[g];
        assign br[g] = b_if.res;
        lmds_sat_lane #(.IW(10)) u_lane(.bus(b_if.lane));
    end

    // ========================================
    // Lane inputs
    always_comb begin
        if (shift_right_in) begin
            shifted = $unsigned($signed(opb_in) >>> shift_amt_in);
        end else begin
            shifted = opb_in << shift_amt_in;
        end
        // Doubling stage, itself saturated before the add
        wv[0] = {opb_in[31], opb_in, 1'b0};
        wn[0] = `LMDS_WORD_N;
        wu[0] = 1'b0;
        wn[1] = `LMDS_WORD_N;
        wu[1] = 1'b0;
        case (op_in)
            op_signed_saturate: begin
                wv[1] = {{2{shifted[31]}}, shifted};
                wn[1] = sat_n_in;
            end
            op_unsigned_saturate: begin
                wv[1] = {{2{shifted[31]}}, shifted};
                wn[1] = sat_n_in;
                wu[1] = 1'b1;
            end
            op_saturating_add: begin
                wv[1] = {{2{opa_in[31]}}, opa_in}
                    + {{2{opb_in[31]}}, opb_in};
            end
            op_saturating_subtract: begin
                wv[1] = {{2{opa_in[31]}}, opa_in}
                    - {{2{opb_in[31]}}, opb_in};
            end
            op_saturating_double_add: begin
                wv[1] = {{2{opa_in[31]}}, opa_in} + wr[0];
            end
            op_saturating_double_subtract: begin
                wv[1] = {{2{opa_in[31]}}, opa_in} - wr[0];
            end
            default: begin
                wv[1] = '0;
            end
        endcase
        hsgn = op_in inside {op_signed_saturate_halfwords,
            op_saturating_subtract_halfwords,
            op_saturating_add_sub_exchange,
            op_saturating_sub_add_exchange};
        for (int h = 0; h < 2; h++) begin
            ah = opa_in[16*h +: 16];
            bo = opb_in[16*h +: 16];
            hadd = op_in == op_unsigned_sat_add_halfwords;
            if (op_in inside {op_saturating_add_sub_exchange,
                op_unsigned_sat_add_sub_exchange}) begin
                bo = opb_in[16*(1-h) +: 16];
                hadd = h == 1;
            end else if (op_in inside {op_saturating_sub_add_exchange,
                op_unsigned_sat_sub_add_exchange}) begin
                bo = opb_in[16*(1-h) +: 16];
                hadd = h == 0;
            end
            hn[h] = `LMDS_HALF_N;
            hu[h] = ~hsgn;
            if (op_in inside {op_signed_saturate_halfwords,
                op_unsigned_saturate_halfwords}) begin
                hv[h] = {{2{opb_in[16*h+15]}}, opb_in[16*h +: 16]};
                hn[h] = sat_n_in;
                hu[h] = op_in == op_unsigned_saturate_halfwords;
            end else if (hadd) begin
                hv[h] = {{2{hsgn & ah[15]}}, ah} + {{2{hsgn & bo[15]}}, bo};
            end else begin
                hv[h] = {{2{hsgn & ah[15]}}, ah} - {{2{hsgn & bo[15]}}, bo};
            end
        end
        for (int k = 0; k < 4; k++) begin
            bu[k] = 1'b1;
            if (op_in == op_unsigned_sat_add_bytes) begin
                bv[k] = {2'b00, opa_in[8*k +: 8]} + {2'b00, opb_in[8*k +: 8]};
            end else begin
                bv[k] = {2'b00, opa_in[8*k +: 8]} - {2'b00, opb_in[8*k +: 8]};
            end
        end
    end

    // ========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.vld = 1'b0;
        prod_u = {32'h0000_0000, opa_in} * {32'h0000_0000, opb_in};
        prod_s = $unsigned($signed({{32{opa_in[31]}}, opa_in})
            * $signed({{32{opb_in[31]}}, opb_in}));
        is_half = op_in inside {op_signed_saturate_halfwords,
            op_unsigned_saturate_halfwords,
            op_saturating_subtract_halfwords,
            op_saturating_add_sub_exchange,
            op_saturating_sub_add_exchange,
            op_unsigned_sat_add_halfwords,
            op_unsigned_sat_add_sub_exchange,
            op_unsigned_sat_sub_add_exchange,
            op_unsigned_sat_subtract_halfwords};
        is_byte = op_in inside {op_unsigned_sat_add_bytes,
            op_unsigned_sat_subtract_bytes};
        trial = {s_r.rem, s_r.quo[31]};
        diff = trial - {1'b0, s_r.dvs};
        ge = trial >= {1'b0, s_r.dvs};
        qnew = {s_r.quo[30:0], ge};
        // only a status write or reset clears the flag
        if (status_wr_in) begin
            s_nxt.q = status_q_in;
        end
        case (s_r.st)
            lmds_st_idle: begin
                if (take) begin
                    s_nxt.vld = 1'b1;
                    s_nxt.lo_idx = dest_lo_idx_in;
                    s_nxt.hi_idx = dest_hi_idx_in;
                    s_nxt.hi_we = 1'b0;
                    // no condition flags are produced here
                    case (op_in)
                        op_unsigned_long_multiply: begin
                            {s_nxt.hi, s_nxt.lo} = prod_u;
                            s_nxt.hi_we = 1'b1;
                        end
                        op_unsigned_long_multiply_accumulate: begin
                            {s_nxt.hi, s_nxt.lo} = prod_u
                                + {acc_hi_in, acc_lo_in};
                            s_nxt.hi_we = 1'b1;
                        end
                        op_signed_long_multiply: begin
                            {s_nxt.hi, s_nxt.lo} = prod_s;
                            s_nxt.hi_we = 1'b1;
                        end
                        op_signed_long_multiply_accumulate: begin
                            {s_nxt.hi, s_nxt.lo} = prod_s
                                + {acc_hi_in, acc_lo_in};
                            s_nxt.hi_we = 1'b1;
                        end
                        // magnitudes, sign fixed at the end
                        op_signed_divide, op_unsigned_divide: begin
                            s_nxt.vld = 1'b0;
                            s_nxt.st = lmds_st_div;
                            s_nxt.busy = 1'b1;
                            s_nxt.cnt = '0;
                            s_nxt.rem = '0;
                            s_nxt.neg = (op_in == op_signed_divide)
                                & (opa_in[31] ^ opb_in[31]);
                            s_nxt.quo = (op_in == op_signed_divide
                                && opa_in[31]) ? -opa_in : opa_in;
                            s_nxt.dvs = (op_in == op_signed_divide
                                && opb_in[31]) ? -opb_in : opb_in;
                            s_nxt.dzero = opb_in == 32'h0000_0000;
                            s_nxt.dst = dest_omitted_in ? first_idx_in
                                : dest_lo_idx_in;
                        end
                        default: begin
                            if (is_half) begin
                                s_nxt.lo = {hr[1][15:0], hr[0][15:0]};
                            end else if (is_byte) begin
                                s_nxt.lo = {br[3][7:0], br[2][7:0],
                                    br[1][7:0], br[0][7:0]};
                            end else begin
                                s_nxt.lo = wr[1][31:0];
                            end
                            // set wins over a same-cycle clear
                            if (ws[1] | (wr[0] != wv[0] && op_in inside
                                {op_saturating_double_add,
                                op_saturating_double_subtract})) begin
                                s_nxt.q = 1'b1;
                            end
                            if ((hs[0] | hs[1]) && op_in inside
                                {op_signed_saturate_halfwords,
                                op_unsigned_saturate_halfwords}) begin
                                s_nxt.q = 1'b1;
                            end
                        end
                    endcase
                end
            end
            lmds_st_div: begin
                s_nxt.cnt = s_r.cnt + 6'd1;
                s_nxt.quo = qnew;
                s_nxt.rem = ge ? diff[31:0] : trial[31:0];
                if (s_r.cnt == `LMDS_DIV_LAST) begin
                    s_nxt.st = lmds_st_idle;
                    s_nxt.busy = 1'b0;
                    s_nxt.vld = 1'b1;
                    s_nxt.hi_we = 1'b0;
                    s_nxt.lo_idx = s_r.dst;
                    // no flag is touched on completion
                    s_nxt.lo = s_r.dzero ? 32'h0000_0000
                        : s_r.neg ? -qnew : qnew;
                end
            end
            default: begin
                s_nxt.st = lmds_st_idle;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_r <= '0;
            s_r.st <= lmds_st_idle;
            s_r.q <= `LMDS_Q_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_out = s_r.busy;
    assign res_valid_out = s_r.vld;
    assign res_lo_out = s_r.lo;
    assign res_hi_out = s_r.hi;
    assign res_hi_we_out = s_r.hi_we;
    assign res_lo_idx_out = s_r.lo_idx;
    assign res_hi_idx_out = s_r.hi_idx;
    assign q_flag_out = s_r.q;

    // ========================================
    // Checks
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    AST_UMUL: assert property (take && op_in == op_unsigned_long_multiply
        |=> res_valid_out && {res_hi_out, res_lo_out}
        == 64'($past(opa_in)) * 64'($past(opb_in)))
        else $error("unsigned long multiply wrong");
    AST_UMAC: assert property (take
        && op_in == op_unsigned_long_multiply_accumulate
        |=> {res_hi_out, res_lo_out} == 64'($past(opa_in))
        * 64'($past(opb_in)) + {$past(acc_hi_in), $past(acc_lo_in)})
        else $error("unsigned accumulate wrong");
    AST_SMUL: assert property (take && op_in == op_signed_long_multiply
        |=> res_hi_we_out && {res_hi_out, res_lo_out}
        == 64'($signed($past(opa_in))) * 64'($signed($past(opb_in))))
        else $error("signed long multiply wrong");
    AST_SMAC: assert property (take
        && op_in == op_signed_long_multiply_accumulate
        |=> {res_hi_out, res_lo_out} == 64'($signed($past(opa_in)))
        * 64'($signed($past(opb_in))) + {$past(acc_hi_in), $past(acc_lo_in)})
        else $error("signed accumulate wrong");
    AST_UNS_QUO: assert property (take && op_in == op_unsigned_divide
        && opb_in != 32'h0000_0000
        |-> ##33 res_valid_out
        && res_lo_out == $past(opa_in, 33) / $past(opb_in, 33))
        else $error("unsigned quotient wrong");
    AST_SGN_QUO: assert property (take && op_in == op_signed_divide
        && opb_in != 32'h0000_0000
        && !(opa_in == 32'h8000_0000 && opb_in == 32'hffff_ffff)
        |-> ##33 res_lo_out == 32'($signed($past(opa_in, 33))
        / $signed($past(opb_in, 33))))
        else $error("signed quotient not truncated");
    AST_DST: assert property (take && dest_omitted_in
        && op_in inside {op_signed_divide, op_unsigned_divide}
        |=> busy_out ##32 res_lo_idx_out == $past(first_idx_in, 33))
        else $error("quotient not sent to dividend");
    AST_DZERO: assert property (take && opb_in == 32'h0000_0000
        && op_in inside {op_signed_divide, op_unsigned_divide}
        |-> ##33 res_valid_out && res_lo_out == 32'h0000_0000)
        else $error("zero divisor result not zero");
    AST_QSET: assert property (take && op_in == op_saturating_add
        && opa_in[31] == opb_in[31]
        && ((opa_in + opb_in) ^ opa_in) >= 32'h8000_0000
        |=> q_flag_out && res_lo_out
        == ($past(opa_in[31]) ? 32'h8000_0000 : 32'h7fff_ffff))
        else $error("saturating add did not clamp");
    AST_UNS_NEG: assert property (take && op_in == op_unsigned_saturate
        && !shift_right_in && shift_amt_in == 5'd0 && opb_in[31]
        |=> res_lo_out == 32'h0000_0000 && q_flag_out)
        else $error("negative not clamped to zero");
    AST_QCLR: assert property ($fell(q_flag_out)
        |-> $past(status_wr_in) && !$past(status_q_in))
        else $error("flag cleared without status write");
endmodule // lmds_unit

//--- tb/lmds_unit_test.sv
`timescale 1ns/1ps
module lmds_unit_test;
    import lmds_pkg::*;
    logic ref_clk_in, srst_in, req_valid_in, shift_right_in, dest_omitted_in;
    logic status_wr_in, status_q_in, busy_out, res_valid_out, res_hi_we_out;
    lmds_op_t op_in;
    logic [31:0] opa_in, opb_in, acc_lo_in, acc_hi_in, res_lo_out, res_hi_out;
    logic [5:0] sat_n_in;
    logic [4:0] shift_amt_in;
    logic [3:0] dest_lo_idx_in, dest_hi_idx_in, first_idx_in;
    logic [3:0] res_lo_idx_out, res_hi_idx_out;
    logic q_flag_out, q_exp;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    lmds_unit u_lmds_unit (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .req_valid_in(req_valid_in), .op_in(op_in), .opa_in(opa_in),
        .opb_in(opb_in), .acc_lo_in(acc_lo_in), .acc_hi_in(acc_hi_in),
        .sat_n_in(sat_n_in), .shift_right_in(shift_right_in),
        .shift_amt_in(shift_amt_in), .dest_lo_idx_in(dest_lo_idx_in),
        .dest_hi_idx_in(dest_hi_idx_in), .first_idx_in(first_idx_in),
        .dest_omitted_in(dest_omitted_in), .status_wr_in(status_wr_in),
        .status_q_in(status_q_in), .busy_out(busy_out),
        .res_valid_out(res_valid_out), .res_lo_out(res_lo_out),
        .res_hi_out(res_hi_out), .res_hi_we_out(res_hi_we_out),
        .res_lo_idx_out(res_lo_idx_out), .res_hi_idx_out(res_hi_idx_out),
        .q_flag_out(q_flag_out));

    // ==========================================
    // Clock, timeout and common tasks
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [63:0] got, exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // Other fields are set by NBA at the same edge as the request
    task automatic issue(input lmds_op_t op, input logic [31:0] a, b,
                         input logic [5:0] n, input logic rsh, input logic [4:0] s,
                         input logic om);
        int i = 0;
        @(posedge ref_clk_in);
        req_valid_in <= 1'b1;
        op_in <= op;
        opa_in <= a;
        opb_in <= b;
        sat_n_in <= n;
        shift_right_in <= rsh;
        shift_amt_in <= s;
        dest_omitted_in <= om;
        @(posedge ref_clk_in);
        req_valid_in <= 1'b0;
        @(negedge ref_clk_in);
        while (res_valid_out !== 1'b1 && i < 40) begin
            @(negedge ref_clk_in);
            i++;
        end
        chk(res_valid_out, 1'b1, "result strobe");
        // Flag lands at the same edge as the data, one more cycle is waited
        @(negedge ref_clk_in);
    endtask
    task automatic opq(input lmds_op_t op, input logic [31:0] a, b, e,
                       input logic s, input logic [5:0] n = 6'd0);
        issue(op, a, b, n, 1'b0, 5'd0, 1'b0);
        if (s) q_exp = 1'b1;
        chk(res_lo_out, e, "sat op result");
        chk(q_flag_out, q_exp, "sat op flag");
    endtask
    // Left preshift works on the 32-bit register, upper bits are lost
    task automatic sat_case(input lmds_op_t op, input logic [5:0] n,
                            input logic rsh, input logic [4:0] s, input logic [31:0] b);
        longint v, lo, hi, r;
        v = rsh ? longint'($signed(b) >>> s) : longint'($signed(b << s));
        lo = (op == op_signed_saturate) ? -(64'sd1 <<< (n - 1)) : 0;
        hi = (op == op_signed_saturate) ? (64'sd1 <<< (n - 1)) - 1 : (64'sd1 <<< n) - 1;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        if (r != v) q_exp = 1'b1;
        issue(op, 32'h0000_0000, b, n, rsh, s, 1'b0);
        chk(res_lo_out, r[31:0], "saturate");
        chk(q_flag_out, q_exp, "sticky flag");
    endtask
    task automatic clear_q();
        @(posedge ref_clk_in);
        status_wr_in <= 1'b1;
        status_q_in <= 1'b0;
        @(posedge ref_clk_in);
        status_wr_in <= 1'b0;
        @(negedge ref_clk_in);
        q_exp = 1'b0;
        chk(q_flag_out, 1'b0, "flag clear");
    endtask

    // ==========================================
    // Scenarios
    task automatic t_sat();
        sat_case(op_signed_saturate, 6'd32, 1'b0, 5'd0, 32'h8000_0000);
        sat_case(op_unsigned_saturate, 6'd31, 1'b0, 5'd0, 32'h7fff_ffff);
        sat_case(op_signed_saturate, 6'd16, 1'b0, 5'd4, 32'h0000_1000);
        sat_case(op_signed_saturate, 6'd8, 1'b1, 5'd4, 32'hffff_f000);
        sat_case(op_signed_saturate, 6'd1, 1'b1, 5'd31, 32'h8000_0000);
        sat_case(op_unsigned_saturate, 6'd7, 1'b0, 5'd0, 32'hffff_ffff);
        sat_case(op_unsigned_saturate, 6'd0, 1'b0, 5'd0, 32'h0000_0005);
        $display("test saturate done");
    endtask
    task automatic t_mul();
        lmds_op_t ops[4] = '{op_unsigned_long_multiply,
            op_unsigned_long_multiply_accumulate, op_signed_long_multiply,
            op_signed_long_multiply_accumulate};
        logic [31:0] a = 32'hffff_fffe;
        logic [31:0] b = 32'h8000_0003;
        logic [63:0] sa, sb, e;
        for (int k = 0; k < 4; k++) begin
            sa = ops[k][1] ? {{32{a[31]}}, a} : {32'h0000_0000, a};
            sb = ops[k][1] ? {{32{b[31]}}, b} : {32'h0000_0000, b};
            e = sa * sb + (ops[k][0] ? {acc_hi_in, acc_lo_in} : 64'h0);
            issue(ops[k], a, b, 6'd0, 1'b0, 5'd0, 1'b0);
            chk({res_hi_out, res_lo_out}, e, "long product");
            // distinct low and high destinations, no SP or PC
            chk({res_hi_we_out, res_hi_idx_out, res_lo_idx_out}, 9'h173, "mul dest");
            chk(q_flag_out, q_exp, "mul flags");
        end
        $display("test multiply done");
    endtask
    task automatic t_div();
        logic [31:0] as[5] = '{32'hffff_fff9, 32'h0000_0007, 32'hffff_fff9,
                               32'h0000_0064, 32'h0000_0009};
        logic [31:0] bs[5] = '{32'h0000_0002, 32'hffff_fffe, 32'h0000_0002,
                               32'h0000_0000, 32'h0000_0004};
        logic sg[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [31:0] e;
        for (int k = 0; k < 5; k++) begin
            e = (bs[k] == 0) ? 32'h0 : (sg[k] ? 32'($signed(as[k]) / $signed(bs[k]))
                                            : as[k] / bs[k]);
            issue(sg[k] ? op_signed_divide : op_unsigned_divide, as[k], bs[k],
                  6'd0, 1'b0, 5'd0, k == 4);
            chk(res_lo_out, e, "quotient");
            chk({res_hi_we_out, res_lo_idx_out}, k == 4 ? 5'h05 : 5'h03, "div dest");
            chk(q_flag_out, q_exp, "div flags");
        end
        $display("test divide done");
    endtask
    task automatic t_ops();
        clear_q();
        opq(op_saturating_subtract_halfwords, 32'h8000_8000, 32'h0001_0001,
            32'h8000_8000, 0);
        opq(op_unsigned_sat_add_bytes, 32'hff10_ff01, 32'h0120_0202,
            32'hff30_ff03, 0);
        opq(op_saturating_add_sub_exchange, 32'h7fff_0005, 32'h0003_0010,
            32'h7fff_0002, 0);
        opq(op_saturating_sub_add_exchange, 32'h7fff_0005, 32'h0003_0010,
            32'h7fef_0008, 0);
        opq(op_unsigned_sat_add_halfwords, 32'hfff0_0005, 32'h0020_0010,
            32'hffff_0015, 0);
        opq(op_unsigned_sat_add_sub_exchange, 32'h0005_0002, 32'h0003_fff0,
            32'hfff5_0000, 0);
        opq(op_unsigned_sat_sub_add_exchange, 32'h0005_0002, 32'h0003_fff0,
            32'h0000_0005, 0);
        opq(op_unsigned_sat_subtract_halfwords, 32'h0010_0005,
            32'h0001_0006, 32'h000f_0000, 0);
        opq(op_unsigned_sat_subtract_bytes, 32'h1005_ff00, 32'h0106_0101,
            32'h0f00_fe00, 0);
        opq(op_saturating_add, 32'h7fff_ffff, 32'h0000_0001, 32'h7fff_ffff, 1);
        clear_q();
        opq(op_signed_saturate_halfwords, 32'h0000_0000, 32'h7fff_8000,
            32'h00ff_ff00, 1, 6'd9);
        clear_q();
        opq(op_unsigned_saturate_halfwords, 32'h0000_0000, 32'h7fff_8000,
            32'h1fff_0000, 1, 6'd13);
        clear_q();
        opq(op_saturating_double_add, 32'h0000_0000, 32'h4000_0000, 32'h7fff_ffff, 1);
        clear_q();
        opq(op_saturating_double_subtract, 32'h8000_0000, 32'h0000_0001,
            32'h8000_0000, 1);
        clear_q();
        opq(op_saturating_subtract, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000, 1);
        $display("test saturating ops done");
    endtask

    task automatic end_sim();
        $display("Totals: %0d compares, %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        srst_in = 1'b1;
        {req_valid_in, shift_right_in, dest_omitted_in, status_wr_in} = 4'h0;
        status_q_in = 1'b0;
        op_in = op_unsigned_long_multiply;
        {opa_in, opb_in} = 64'h0;
        acc_lo_in = 32'h0000_0001;
        acc_hi_in = 32'hffff_ffff;
        {sat_n_in, shift_amt_in} = 11'h0;
        dest_lo_idx_in = 4'h3;
        dest_hi_idx_in = 4'h7;
        first_idx_in = 4'h5;
        q_exp = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(negedge ref_clk_in);
        chk({res_valid_out, busy_out, q_flag_out}, 3'h0, "reset outputs");
        t_sat();
        t_mul();
        t_div();
        t_ops();
        end_sim();
    end
endmodule // lmds_unit_test
